/* pkg/pioc_pkg.sv */
// Constants and carrier types for the programmable I/O cell block.
// Assumes a single 200 MHz system clock; every other clock arrives as a sampled level.
package pioc_pkg;

	////////////////////////////////////////////////////////////////////////////
	localparam int NSLICE = 2;
	localparam int DLY_TAPS = 16;
	localparam int CLK_PERIOD_PS = 5000;
	localparam int SHIFT_STEP_PS = 25;
	localparam int SHIFT_STEPS = 128;

	// Register offsets (byte addresses)
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_SHIFT = 4'h4;
	localparam logic [3:0] ADDR_STATUS = 4'h8;

	// Control register field positions
	localparam int CTL_MODE_LSB = 0;
	localparam int CTL_X2 = 2;
	localparam int CTL_ECLK_SEL = 3;
	localparam int CTL_SRVAL = 4;
	localparam int CTL_STATIC_EN = 5;
	localparam int CTL_CLKIN_LSB = 6;
	localparam int CTL_STROBE_LSB = 8;
	localparam int CTL_FIXDLY_SEL = 10;
	localparam int CTL_FIXDLY_LSB = 12;

	// Status register field positions
	localparam int STS_DLL_LSB = 0;
	localparam int STS_SHIFT_LSB = 8;
	localparam int STS_PREAMBLE = 16;
	localparam int STS_VALID_LSB = 17;
	localparam int STS_PHASE_LSB = 19;

	// Reset values
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [7:0] SHIFT_RST = 8'h00;

	// Capture modes
	localparam logic [1:0] MODE_SDR = 2'h0;
	localparam logic [1:0] MODE_DDR_GEN = 2'h1;
	localparam logic [1:0] MODE_DDR_MEM = 2'h2;

	////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic rise_a;
		logic fall_a;
		logic rise_b;
		logic fall_b;
	} pioc_quad_t;

	typedef struct packed {
		logic [NSLICE-1:0] pad;
		logic edge_clock_one;
		logic edge_clock_two;
		logic rstrobe;
		logic wclk0;
		logic wclk1;
		logic swclk;
		logic strobe;
		logic strobe_act;
	} pioc_sync_t;

	typedef struct packed {
		logic [DLY_TAPS-1:0] dly;
		logic cap_rise;
		logic cap_fall;
		logic hold_rise;
		logic hold_fall;
		logic phase;
		pioc_quad_t din;
		pioc_quad_t dout;
		logic ts;
		logic pad_out;
		logic pad_ts;
		logic byp;
		logic clkp;
		logic valid;
	} pioc_slice_t;

	typedef struct packed {
		pioc_sync_t s1;
		pioc_sync_t s2;
		logic cap_prev;
		logic xpend;
		logic pre;
		logic pre_seen;
		logic [15:0] ctrl;
		logic [7:0] shift;
		logic ack;
		logic [31:0] dat;
		pioc_slice_t [NSLICE-1:0] sl;
	} pioc_state_t;

endpackage : pioc_pkg

/* rtl/pioc_io_cell.sv */
// I/O cell with two slices: pad datapath, input gearing, output gearing, Wishbone config.
// Assumes all clocks other than clk_i are sampled levels; edges are found by the system clock.
// Function
// - Cell holds two slices, each driving data and tristate, reading its pad.
// - Unregistered-path copy of the pad input is offered to the core.
// - Registered input data reaches core on four ports per slice.
// - Clock enable holds input and output block flip-flops when low.
// - System clock clocks the input, output and tristate blocks.
// - One of two edge clocks is selected for the whole slice.
// - Shifted read strobe captures read data only in memory-interface mode.
// - Sync polarity picks which strobe edge moves data to system domain.
// - Gearing latch enable gates the second-stage flop for x2 input gearing.
// - Four-bit dynamic delay code selects the pad input delay.
// - In clock-input use the pad goes out on input_clock_path.
// - Output gearing is clocked by two quadrature write clocks.
// - Strobe write clock drives output only in the strobe slice.
// - Write clock shift: seven step bits and an invert bit seven.
// - A static eight-bit value can replace the dynamic write clock shift.
// - Slice receives the seven-bit delay code from the delay-locked loop.
// - Capture valid flag marks input data captured and valid for core.
// - Strobe biased high while tristated gives preamble detect to logic and core.
// - DDR controls and capture flag exist only on left, right, top slices.
// - Input gearbox turns double rate pad data into four streams.
`timescale 1ns/10ps
module pioc_io_cell
	import pioc_pkg::*;
#(
	parameter bit HAS_DDR = 1'b1
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o,
	// Pad buffers
	input wire logic [NSLICE-1:0] pad_in_i,
	output logic [NSLICE-1:0] pad_out_o,
	output logic [NSLICE-1:0] pad_tristate_ctrl_o,
	// Core data
	input wire logic [NSLICE-1:0] rise_out_a_i,
	input wire logic [NSLICE-1:0] fall_out_a_i,
	input wire logic [NSLICE-1:0] rise_out_b_i,
	input wire logic [NSLICE-1:0] fall_out_b_i,
	input wire logic [NSLICE-1:0] core_tristate_i,
	output logic [NSLICE-1:0] rise_in_a_o,
	output logic [NSLICE-1:0] fall_in_a_o,
	output logic [NSLICE-1:0] rise_in_b_o,
	output logic [NSLICE-1:0] fall_in_b_o,
	output logic [NSLICE-1:0] bypass_input_o,
	output logic [NSLICE-1:0] input_clock_path_o,
	output logic [NSLICE-1:0] capture_valid_flag_o,
	// Slice control from fabric
	input wire logic ce_i,
	input wire logic local_set_reset_i,
	input wire logic global_set_reset_n_i,
	input wire logic sync_clock_polarity_i,
	input wire logic gearing_latch_enable_i,
	input wire logic [3:0] input_delay_code_i,
	input wire logic [7:0] write_clock_shift_i,
	input wire logic [6:0] dll_delay_code_i,
	input wire logic read_window_i,
	// Clocks sampled as levels
	input wire logic edge_clock_one_i,
	input wire logic edge_clock_two_i,
	input wire logic shifted_read_strobe_i,
	input wire logic write_gear_clock_0_i,
	input wire logic write_gear_clock_1_i,
	input wire logic strobe_write_clock_i,
	// Strobe pad
	input wire logic raw_strobe_in_i,
	input wire logic raw_strobe_driven_i,
	output logic preamble_detect_o
);

	////////////////////////////////////////////////////////////////////////////
	pioc_state_t r;
	pioc_state_t n;

	always_comb begin
		logic [1:0] mode;
		logic ddr;
		logic x2;
		logic sr;
		logic srv;
		logic cap_lvl;
		logic out_lvl;
		logic rise_ev;
		logic fall_ev;
		logic win;
		logic [7:0] eff_shift;
		logic wc0;
		logic wc1;
		logic [3:0] code;
		logic tap;
		logic req;
		logic [31:0] wmask;
		mode = 2'h0;
		ddr = 1'b0;
		x2 = 1'b0;
		sr = 1'b0;
		srv = 1'b0;
		cap_lvl = 1'b0;
		out_lvl = 1'b0;
		rise_ev = 1'b0;
		fall_ev = 1'b0;
		win = 1'b0;
		eff_shift = 8'h00;
		wc0 = 1'b0;
		wc1 = 1'b0;
		code = 4'h0;
		tap = 1'b0;
		req = 1'b0;
		wmask = 32'h00000000;
		n = r;

		// Two-flop synchronisers for every off-domain input
		n.s1.pad = pad_in_i;
		n.s1.edge_clock_one = edge_clock_one_i;
		n.s1.edge_clock_two = edge_clock_two_i;
		n.s1.rstrobe = shifted_read_strobe_i;
		n.s1.wclk0 = write_gear_clock_0_i;
		n.s1.wclk1 = write_gear_clock_1_i;
		n.s1.swclk = strobe_write_clock_i;
		n.s1.strobe = raw_strobe_in_i;
		n.s1.strobe_act = raw_strobe_driven_i;
		n.s2 = r.s1;

		// Mode decode; a slice without DDR hardware is forced to SDR
		mode = HAS_DDR ? r.ctrl[CTL_MODE_LSB +: 2] : MODE_SDR;
		ddr = (mode == MODE_DDR_GEN) || (mode == MODE_DDR_MEM);
		x2 = ddr && r.ctrl[CTL_X2];
		srv = r.ctrl[CTL_SRVAL];
		sr = local_set_reset_i || !global_set_reset_n_i;

		out_lvl = r.ctrl[CTL_ECLK_SEL] ? r.s2.edge_clock_two : r.s2.edge_clock_one;
		cap_lvl = (mode == MODE_DDR_MEM) ? r.s2.rstrobe : out_lvl;
		n.cap_prev = cap_lvl;
		rise_ev = cap_lvl && !r.cap_prev;
		fall_ev = !cap_lvl && r.cap_prev;

		// Strobe pad floats high when not driven
		n.pre = r.s2.strobe_act ? r.s2.strobe : 1'b1;
		if (!read_window_i) begin
			n.pre_seen = 1'b0;
		end else if (!r.pre) begin
			n.pre_seen = 1'b1;
		end
		win = (mode == MODE_DDR_MEM) ? (read_window_i && r.pre_seen) : 1'b1;

		// Transfer waits one cycle so both captured halves are stable
		n.xpend = ddr && win && (sync_clock_polarity_i ? rise_ev : fall_ev);

		eff_shift = r.ctrl[CTL_STATIC_EN] ? r.shift : write_clock_shift_i;
		wc0 = r.s2.wclk0 ^ eff_shift[7];
		wc1 = r.s2.wclk1 ^ eff_shift[7];
		code = r.ctrl[CTL_FIXDLY_SEL] ? r.ctrl[CTL_FIXDLY_LSB +: 4] : input_delay_code_i;

		////////////////////////////////////////////////////////////////////////
		for (int i = 0; i < NSLICE; i++) begin
			n.sl[i].valid = 1'b0;
			n.sl[i].dly = {r.sl[i].dly[DLY_TAPS-2:0], r.s2.pad[i]};
			tap = (code == 4'h0) ? r.s2.pad[i] : r.sl[i].dly[code - 4'h1];
			n.sl[i].byp = r.s2.pad[i];
			n.sl[i].clkp = r.ctrl[CTL_CLKIN_LSB + i] && r.s2.pad[i];
			if (sr) begin
				n.sl[i].cap_rise = srv;
				n.sl[i].cap_fall = srv;
				n.sl[i].hold_rise = srv;
				n.sl[i].hold_fall = srv;
				n.sl[i].phase = 1'b0;
				n.sl[i].din = {4{srv}};
				n.sl[i].dout = {4{srv}};
				n.sl[i].ts = srv;
				n.sl[i].pad_out = srv;
				n.sl[i].pad_ts = srv;
			end else if (ce_i) begin
				n.sl[i].dout = {rise_out_a_i[i], fall_out_a_i[i], rise_out_b_i[i], fall_out_b_i[i]};
				n.sl[i].ts = core_tristate_i[i];
				if (!ddr) begin
					n.sl[i].din.rise_a = tap;
					n.sl[i].valid = HAS_DDR;
					n.sl[i].pad_out = rise_out_a_i[i];
					n.sl[i].pad_ts = core_tristate_i[i];
				end else begin
					if (rise_ev && win) begin
						n.sl[i].cap_rise = tap;
					end
					if (fall_ev && win) begin
						n.sl[i].cap_fall = tap;
					end
					if (r.xpend && !x2) begin
						n.sl[i].din.rise_a = r.sl[i].cap_rise;
						n.sl[i].din.fall_a = r.sl[i].cap_fall;
						n.sl[i].valid = 1'b1;
					end else if (r.xpend && !r.sl[i].phase) begin
						n.sl[i].hold_rise = r.sl[i].cap_rise;
						n.sl[i].hold_fall = r.sl[i].cap_fall;
						n.sl[i].phase = 1'b1;
					end else if (r.xpend && gearing_latch_enable_i) begin
						n.sl[i].din = {r.sl[i].hold_rise, r.sl[i].hold_fall,
							r.sl[i].cap_rise, r.sl[i].cap_fall};
						n.sl[i].phase = 1'b0;
						n.sl[i].valid = 1'b1;
					end
					// Output side
					if (r.ctrl[CTL_STROBE_LSB + i]) begin
						n.sl[i].pad_out = r.s2.swclk ^ eff_shift[7];
						n.sl[i].pad_ts = r.sl[i].dout.fall_b;
					end else if (x2) begin
						// Quadrature phases walk the four streams in turn
						case ({wc0, wc1})
							2'b10: n.sl[i].pad_out = r.sl[i].dout.rise_a;
							2'b11: n.sl[i].pad_out = r.sl[i].dout.fall_a;
							2'b01: n.sl[i].pad_out = r.sl[i].dout.rise_b;
							default: n.sl[i].pad_out = r.sl[i].dout.fall_b;
						endcase
						n.sl[i].pad_ts = r.sl[i].ts;
					end else begin
						n.sl[i].pad_out = out_lvl ? r.sl[i].dout.rise_a : r.sl[i].dout.fall_a;
						n.sl[i].pad_ts = r.sl[i].ts;
					end
				end
			end
		end

		////////////////////////////////////////////////////////////////////////
		// Wishbone classic slave, one wait state, ack lasts one cycle
		req = wb_cyc_i && wb_stb_i && !r.ack;
		n.ack = req;
		for (int b = 0; b < 4; b++) begin
			wmask[b*8 +: 8] = wb_sel_i[b] ? 8'hFF : 8'h00;
		end
		if (req && wb_we_i) begin
			if (wb_adr_i == ADDR_CTRL) begin
				n.ctrl = (r.ctrl & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
			end else if (wb_adr_i == ADDR_SHIFT) begin
				n.shift = (r.shift & ~wmask[7:0]) | (wb_dat_i[7:0] & wmask[7:0]);
			end
		end
		n.dat = 32'h00000000;
		if (req && !wb_we_i) begin
			if (wb_adr_i == ADDR_CTRL) begin
				n.dat[15:0] = r.ctrl;
			end else if (wb_adr_i == ADDR_SHIFT) begin
				n.dat[7:0] = r.shift;
			end else if (wb_adr_i == ADDR_STATUS) begin
				n.dat[STS_DLL_LSB +: 7] = dll_delay_code_i;
				n.dat[STS_SHIFT_LSB +: 8] = eff_shift;
				n.dat[STS_PREAMBLE] = r.pre;
				n.dat[STS_VALID_LSB] = r.sl[0].valid;
				n.dat[STS_VALID_LSB + 1] = r.sl[1].valid;
				n.dat[STS_PHASE_LSB] = r.sl[0].phase;
				n.dat[STS_PHASE_LSB + 1] = r.sl[1].phase;
			end
		end

		if (rst_i) begin
			n = '0;
			n.ctrl = CTRL_RST;
			n.shift = SHIFT_RST;
			n.pre = 1'b1;
			for (int i = 0; i < NSLICE; i++) begin
				n.sl[i].pad_ts = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		r <= n;
	end

	////////////////////////////////////////////////////////////////////////////
	assign wb_ack_o = r.ack;
	assign wb_dat_o = r.dat;
	assign preamble_detect_o = r.pre;

	for (genvar g = 0; g < NSLICE; g++) begin : g_out
		assign pad_out_o[g] = r.sl[g].pad_out;
		assign pad_tristate_ctrl_o[g] = r.sl[g].pad_ts;
		assign rise_in_a_o[g] = r.sl[g].din.rise_a;
		assign fall_in_a_o[g] = r.sl[g].din.fall_a;
		assign rise_in_b_o[g] = r.sl[g].din.rise_b;
		assign fall_in_b_o[g] = r.sl[g].din.fall_b;
		assign bypass_input_o[g] = r.sl[g].byp;
		assign input_clock_path_o[g] = r.sl[g].clkp;
		assign capture_valid_flag_o[g] = r.sl[g].valid;
	end

endmodule : pioc_io_cell

/* verif/pioc_far_side.sv */
// Far-side model: pad buffers with loopback, edge clock sources and the strobe pad.
// Assumes the bench drives the external pad value while a lane is tristated.
`timescale 1ns/10ps
module pioc_far_side
	import pioc_pkg::*;
(
	// Clock and design side
	input wire logic clk_i,
	input wire logic [NSLICE-1:0] pad_out_i,
	input wire logic [NSLICE-1:0] pad_ts_i,
	// Bench controls
	input wire logic [NSLICE-1:0] ext_i,
	input wire logic [1:0] run_i,
	input wire logic sen_i,
	input wire logic sval_i,
	// Towards the design
	output logic [NSLICE-1:0] pad_in_o,
	output logic [1:0] eclk_o,
	output logic strobe_o,
	output logic strobe_drv_o
);
	logic last_r = 1'h0;
	////////////////////////////////////////
	// Driven lanes loop back, tristated lanes read the outside driver
	assign pad_in_o = (pad_ts_i & ext_i) | (~pad_ts_i & pad_out_i);
	// Edge clocks stand still unless running; phase unrelated to clk_i
	initial begin
		eclk_o = 2'h0;
		#1.3;
		forever #62.5 eclk_o = eclk_o ^ run_i;
	end
	always @(posedge clk_i) begin
		if (sen_i) begin
			last_r <= sval_i;
		end
	end
	// A released strobe line shows the inverse of its last level, not a bias
	assign strobe_o = sen_i ? sval_i : ~last_r;
	assign strobe_drv_o = sen_i;
endmodule : pioc_far_side

/* verif/pioc_io_cell_monitor.sv */
// Checker for the I/O cell: bus timing, SDR paths, enables, set/reset, strobe bias.
// Assumes it is bound to pioc_io_cell; follows the low CTRL byte from bus writes.
`timescale 1ns/10ps
module pioc_io_cell_monitor
	import pioc_pkg::*;
(
	// Clock, reset and bus
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	// Slice
	input wire logic [NSLICE-1:0] pad_in_i,
	input wire logic [NSLICE-1:0] pad_out_o,
	input wire logic [NSLICE-1:0] pad_tristate_ctrl_o,
	input wire logic [NSLICE-1:0] rise_out_a_i,
	input wire logic [NSLICE-1:0] core_tristate_i,
	input wire logic [NSLICE-1:0] rise_in_a_o,
	input wire logic [NSLICE-1:0] bypass_input_o,
	input wire logic ce_i,
	input wire logic local_set_reset_i,
	input wire logic global_set_reset_n_i,
	input wire logic raw_strobe_driven_i,
	input wire logic preamble_detect_o
);
	logic [7:0] ctl_r;
	logic run;
	logic wr_ctl;
	assign wr_ctl = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == ADDR_CTRL;
	assign run = ctl_r[1:0] == MODE_SDR && !local_set_reset_i && global_set_reset_n_i;
	// Write lands on the taking edge, as the design does
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctl_r <= 8'h00;
		end else if (wr_ctl) begin
			ctl_r <= wb_dat_i[7:0];
		end
	end
	////////////////////////////////////////
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered in the next cycle");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data not zero outside ack");
	bypass_path_a: assert property ($stable(pad_in_i) [*4] |-> bypass_input_o == pad_in_i)
		else $error("bypass input does not follow the pad");
	sdr_out_a: assert property (run && ce_i |=>
		pad_out_o == $past(rise_out_a_i) && pad_tristate_ctrl_o == $past(core_tristate_i))
		else $error("SDR output or tristate not registered from core");
	ce_hold_a: assert property (run && !ce_i |=> $stable(pad_out_o) && $stable(rise_in_a_o))
		else $error("flops moved with clock enable low");
	sr_force_a: assert property (local_set_reset_i || !global_set_reset_n_i |=>
		pad_out_o == {NSLICE{ctl_r[4]}} && rise_in_a_o == {NSLICE{ctl_r[4]}})
		else $error("set/reset did not force the slice flops");
	strobe_bias_a: assert property (!raw_strobe_driven_i [*4] |-> preamble_detect_o)
		else $error("released strobe not biased high");
endmodule : pioc_io_cell_monitor
bind pioc_io_cell pioc_io_cell_monitor mon (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_dat_i, .wb_ack_o, .wb_dat_o, .pad_in_i, .pad_out_o, .pad_tristate_ctrl_o,
	.rise_out_a_i, .core_tristate_i, .rise_in_a_o, .bypass_input_o, .ce_i, .local_set_reset_i,
	.global_set_reset_n_i, .raw_strobe_driven_i, .preamble_detect_o);

/* verif/pioc_io_cell_test.sv */
// Self-checking bench: registers, SDR paths, enables, set/reset, strobe, edge clocks.
// Assumes the far-side model and the bound checker; clk_i runs at 200 MHz.
`timescale 1ns/10ps
module pioc_io_cell_test;
	import pioc_pkg::*;
	logic clk_i = 1'h0, rst_i = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0, ce = 1'h1;
	logic local_set_reset = 1'h0, gsr_n = 1'h1, pol = 1'h0, lat = 1'h0, sen = 1'h0, sval = 1'h0;
	logic rw = 1'h0, rds = 1'h0;
	logic [3:0] adr = 4'h0, sel = 4'hF, dly = 4'h0;
	logic [31:0] dw = 32'h0, q, dr;
	logic [1:0] ro = 2'h0, ts = 2'h3, ext = 2'h0, run = 2'h0, eclk, pad_o, pad_t, pad_i, ria, cvf;
	logic ack, strobe, sdrv, pre;
	int bad_count = 0, check_count = 0, n;
	pioc_io_cell uut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_ack_o(ack), .wb_dat_o(dr),
		.pad_in_i(pad_i), .pad_out_o(pad_o), .pad_tristate_ctrl_o(pad_t), .rise_out_a_i(ro),
		.fall_out_a_i(~ro), .rise_out_b_i(ro), .fall_out_b_i(~ro), .core_tristate_i(ts),
		.rise_in_a_o(ria), .fall_in_a_o(), .rise_in_b_o(), .fall_in_b_o(), .bypass_input_o(),
		.input_clock_path_o(), .capture_valid_flag_o(cvf), .ce_i(ce), .local_set_reset_i(local_set_reset),
		.global_set_reset_n_i(gsr_n), .sync_clock_polarity_i(pol), .gearing_latch_enable_i(lat),
		.input_delay_code_i(dly), .write_clock_shift_i(8'hC3), .dll_delay_code_i(7'h55),
		.read_window_i(rw), .edge_clock_one_i(eclk[0]), .edge_clock_two_i(eclk[1]),
		.shifted_read_strobe_i(rds), .write_gear_clock_0_i(1'h0), .write_gear_clock_1_i(1'h0),
		.strobe_write_clock_i(1'h0), .raw_strobe_in_i(strobe), .raw_strobe_driven_i(sdrv),
		.preamble_detect_o(pre));
	pioc_far_side far (.clk_i, .pad_out_i(pad_o), .pad_ts_i(pad_t), .ext_i(ext), .run_i(run),
		.sen_i(sen), .sval_i(sval), .pad_in_o(pad_i), .eclk_o(eclk), .strobe_o(strobe),
		.strobe_drv_o(sdrv));
	////////////////////////////////////////
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			bad_count++;
		end
	endtask : chk
	task wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk_i);
		{cyc, stb, we, adr, dw, sel} <= {2'h3, w, a, d, s};
		do @(posedge clk_i); while (ack !== 1'h1);
		q = dr;
		{cyc, stb} <= 2'h0;
	endtask : wb
	task rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
		wb(1'h0, a, 32'h0, 4'hF);
		chk(q & m, e);
	endtask : rd
	task tick(input int k);
		repeat (k) @(posedge clk_i);
	endtask : tick
	task regs;
		wb(1'h1, ADDR_CTRL, 32'hFFFF_F458, 4'h3);
		wb(1'h1, ADDR_CTRL, 32'h0000_0050, 4'h1);
		rd(ADDR_CTRL, 32'hFFFF_FFFF, 32'h0000_F450);
		wb(1'h1, ADDR_SHIFT, 32'h0000_015A, 4'hF);
		rd(ADDR_SHIFT, 32'hFFFF_FFFF, 32'h0000_005A);
		wb(1'h1, ADDR_STATUS, 32'hFFFF_FFFF, 4'hF);
		rd(ADDR_STATUS, 32'h0000_FFFF, 32'h0000_C355);
		wb(1'h1, ADDR_CTRL, 32'h0000_0020, 4'hF);
		rd(ADDR_STATUS, 32'h0000_FF00, 32'h0000_5A00);
		rd(4'hC, 32'hFFFF_FFFF, 32'h0);
		wb(1'h1, ADDR_CTRL, 32'h0, 4'hF);
	endtask : regs
	task sdr_in(input logic [3:0] d, input int e);
		{dly, ts, ext} <= {d, 4'hC};
		tick(24);
		ext <= 2'h3;
		n = 0;
		do begin
			@(posedge clk_i);
			#1;
			n++;
		end while (ria !== 2'h3 && n < 40);
		chk(32'(n), 32'(e));
	endtask : sdr_in
	task sdr_out;
		{ts, ro} <= 4'h9;
		tick(6);
		chk({pad_t, pad_o, ria}, 32'h27);
		{ce, ro} <= 3'h2;
		tick(4);
		chk(pad_o, 32'h1);
		ce <= 1'h1;
		wb(1'h1, ADDR_CTRL, 32'h10, 4'hF);
		local_set_reset <= 1'h1;
		tick(2);
		chk({pad_o, ria}, 32'hF);
		local_set_reset <= 1'h0;
		wb(1'h1, ADDR_CTRL, 32'h0, 4'hF);
		gsr_n <= 1'h0;
		tick(2);
		chk({pad_o, ria}, 32'h0);
		gsr_n <= 1'h1;
	endtask : sdr_out
	task strobe_bias;
		{sen, sval} <= 2'h2;
		tick(5);
		chk(pre, 32'h0);
		sval <= 1'h1;
		tick(2);
		sen <= 1'h0;
		tick(5);
		chk(pre, 32'h1);
	endtask : strobe_bias
	// Read strobe toggles all along; only memory mode may capture on it
	task count_valid;
		tick(10);
		n = 0;
		for (int k = 0; k < 400; k++) begin
			@(posedge clk_i);
			if (k % 8 == 7) begin
				rds <= ~rds;
			end
			n += int'(cvf !== 2'h0);
		end
	endtask : count_valid
	task edge_sel;
		wb(1'h1, ADDR_CTRL, 32'h1, 4'hF);
		run <= 2'h1;
		count_valid();
		chk(32'(n > 0), 32'h1);
		wb(1'h1, ADDR_CTRL, 32'h9, 4'hF);
		count_valid();
		chk(32'(n), 32'h0);
		wb(1'h1, ADDR_CTRL, 32'h101, 4'hF);
		ro <= 2'h2;
		tick(4);
		chk({pad_t[0], pad_o[0]}, 32'h3);
		run <= 2'h0;
		wb(1'h1, ADDR_CTRL, 32'h0, 4'hF);
	endtask : edge_sel
	// Memory mode captures only inside the read window after a low preamble
	task mem_read;
		wb(1'h1, ADDR_CTRL, 32'h2, 4'hF);
		rw <= 1'h1;
		count_valid();
		chk(32'(n), 32'h0);
		{sen, sval} <= 2'h2;
		count_valid();
		chk(32'(n > 0), 32'h1);
		rw <= 1'h0;
		count_valid();
		chk(32'(n), 32'h0);
		sen <= 1'h0;
		wb(1'h1, ADDR_CTRL, 32'h0, 4'hF);
	endtask : mem_read
	task summarize;
		$display("checks %0d, mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : summarize
	////////////////////////////////////////
	initial forever #2.5 clk_i = ~clk_i;
	initial begin
		tick(5);
		chk({pad_t, ria, pre}, 32'h19);
		rst_i <= 1'h0;
		regs();
		sdr_in(4'h0, 3);
		sdr_in(4'hF, 18);
		sdr_out();
		strobe_bias();
		edge_sel();
		mem_read();
		summarize();
	end
	// Whole run is a few thousand cycles; this limit only cuts a hang
	initial begin
		#50000;
		bad_count++;
		summarize();
	end
endmodule : pioc_io_cell_test
